// *** grf_slave.sv ***
`timescale 1ns/1ns
`default_nettype none
module grf_slave import grf_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     resetn,
	// serial bus
	grf_bus_if.slave                      bus,
	// user side
	input  wire logic                     bankSel,
	input  wire logic                     progReq,
	input  wire logic                     progBank,
	input  wire logic                     drainHold,
	output logic [CH_N*CODE_W-1:0]        chanCode,
	output logic                          hsMode,
	output logic [4:0]                    nvWritesLeft,
	output logic                          bankActive
);
	typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_RXACK} grf_sst_e;
	typedef enum logic [2:0] {R_ADDR, R_GC, R_PTR, R_HI, R_LO} grf_role_e;
	typedef logic [CH_N-1:0][CODE_W-1:0] grf_curve_t;
	typedef struct packed {
		logic [2:0]              scl;
		logic [2:0]              sda;
		logic [2:0]              bank;
		grf_sst_e                st;
		grf_sst_e                nxt;
		grf_role_e               role;
		logic [3:0]              cnt;
		logic [7:0]              sh;
		logic                    ackOn;
		logic                    ackWant;
		logic                    gcReset;
		logic [5:0]              ptr;
		logic [7:0]              hi;
		logic                    hs;
		logic                    sdaOe;
		logic                    pushV;
		logic [WORD_W-1:0]       pushW;
		grf_curve_t              shadow;
		grf_curve_t              chan;
		logic [BANK_N-1:0][CH_N-1:0][CODE_W-1:0] nv;
		logic [BANK_N-1:0]       nvSet;
		logic [4:0]              left;
	} grf_slave_s;
	grf_slave_s q, d;

	logic              fifoReady;
	logic              drainValid;
	logic [WORD_W-1:0] drainWord;

	function automatic logic isStore(input logic [5:0] p);
		return (p <= GAMMA_LAST) || (p == COM0_PTR) || (p == COM1_PTR);
	endfunction : isStore

	function automatic logic [4:0] chOf(input logic [5:0] p);
		return (p <= GAMMA_LAST) ? p[4:0] : ((p == COM0_PTR) ? 5'h10 : 5'h11);
	endfunction : chOf

	grf_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) uFifo (
		.clk      (clk),
		.resetn   (resetn),
		.inValid  (q.pushV),
		.inReady  (fifoReady),
		.inData   (q.pushW),
		.outValid (drainValid),
		.outReady (!drainHold),
		.outData  (drainWord)
	);

	assign bus.sdaOS    = 1'b0; // RULE_05
	assign bus.sdaOeS   = q.sdaOe;
	assign chanCode     = q.chan;
	assign hsMode       = q.hs;
	assign nvWritesLeft = q.left;
	assign bankActive   = q.bank[2];

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic       sclRise;
		logic       sclFall;
		logic       sclHi;
		logic       start;
		logic       stop;
		logic [7:0] b;
		logic [9:0] rv;
		logic [7:0] txB;
		logic       bk;
		grf_curve_t ld;
		grf_curve_t tmp;
		d = q;
		d.scl = {q.scl[1:0], bus.scl};
		d.sda = {q.sda[1:0], bus.sda};
		d.bank = {q.bank[1:0], bankSel};
		d.pushV = 1'b0;
		// only the second and third stages are looked at, never the first
		sclRise = q.scl[1] && !q.scl[2];
		sclFall = !q.scl[1] && q.scl[2];
		sclHi = q.scl[1] && q.scl[2];
		start = sclHi && !q.sda[1] && q.sda[2]; // RULE_07 RULE_12
		stop = sclHi && q.sda[1] && !q.sda[2]; // RULE_12 RULE_14
		b = {q.sh[6:0], q.sda[1]}; // RULE_18
		rv = isStore(q.ptr) ? q.shadow[chOf(q.ptr)] : '0;
		txB = (q.role == R_HI) ? {6'h00, rv[9:8]} : rv[7:0];
		bk = q.bank[2];
		ld = q.nvSet[bk] ? q.nv[bk] : {CH_N{CODE_RESET}};
		// register writes land in the shadow; a set update bit copies all to the outputs
		tmp = q.shadow;
		if (drainValid && !drainHold) begin
			tmp[chOf(drainWord[15:10])] = drainWord[9:0]; // RULE_01
			d.shadow = tmp;
			if (drainWord[16]) begin
				d.chan = tmp;
			end
		end
		if (progReq && q.left != 5'h00) begin
			d.nv[progBank] = tmp; // RULE_03
			d.nvSet[progBank] = 1'b1;
			d.left = q.left - 5'h01; // RULE_02
		end
		if (q.bank[1] != q.bank[2]) begin
			d.shadow = q.nvSet[q.bank[1]] ? q.nv[q.bank[1]] : {CH_N{CODE_RESET}}; // RULE_03
			d.chan = d.shadow;
		end
		if (stop) begin
			d.st = S_IDLE;
			d.hs = 1'b0; // RULE_16
			d.sdaOe = 1'b0;
			d.ackOn = 1'b0;
			d.gcReset = 1'b0;
		end else if (start) begin
			// a repeated start keeps the speed mode
			d.st = S_RX; // RULE_16
			d.role = R_ADDR;
			d.cnt = 4'h0;
			d.sdaOe = 1'b0;
			d.ackOn = 1'b0;
			d.gcReset = 1'b0;
		end else begin
			unique case (q.st)
				S_IDLE: begin
				end
				S_RX: begin
					if (sclRise) begin
						d.sh = b; // RULE_08
						d.cnt = q.cnt + 4'h1;
						if (q.cnt == 4'h7) begin
							d.st = S_ACK; // RULE_10
							d.ackWant = 1'b0;
							d.nxt = S_IDLE;
							unique case (q.role)
								R_ADDR: begin
									if (b[7:3] == HS_CODE) begin
										d.hs = 1'b1; // RULE_15
									end else if (b == GC_ADDR) begin
										d.ackWant = 1'b1; // RULE_17
										d.role = R_GC;
										d.nxt = S_RX;
									end else if (b[7:1] == DEV_ADDR) begin
										d.ackWant = 1'b1; // RULE_09 RULE_04
										d.role = b[0] ? R_HI : R_PTR;
										d.nxt = b[0] ? S_TX : S_RX;
									end
								end
								R_GC: begin
									if (b == GC_RESET) begin
										d.ackWant = 1'b1; // RULE_17
										d.gcReset = 1'b1;
									end
								end
								R_PTR: begin
									d.ackWant = (b[7:6] == 2'b00) && (b[5:0] <= PTR_LAST_ACK);
									d.ptr = b[5:0];
									d.role = R_HI;
									d.nxt = S_RX;
								end
								R_HI: begin
									d.ackWant = 1'b1;
									d.hi = b;
									d.role = R_LO;
									d.nxt = S_RX;
								end
								R_LO: begin
									// a full queue refuses the byte by leaving it unacknowledged
									d.ackWant = fifoReady;
									d.pushV = fifoReady && isStore(q.ptr);
									d.pushW = {q.hi[7], q.ptr, q.hi[1:0], b};
									d.ptr = q.ptr + 6'h01;
									d.role = R_HI;
									d.nxt = S_RX;
								end
								default: begin
								end
							endcase
						end
					end
				end
				S_ACK: begin
					if (sclFall) begin
						if (!q.ackOn) begin
							d.ackOn = 1'b1;
							d.sdaOe = q.ackWant; // RULE_09 RULE_11
						end else begin
							d.ackOn = 1'b0;
							d.sdaOe = 1'b0;
							d.cnt = 4'h0;
							d.st = q.ackWant ? q.nxt : S_IDLE;
							if (q.ackWant && q.nxt == S_TX) begin
								d.sh = txB;
								d.sdaOe = !txB[7]; // RULE_18 RULE_11
							end
							if (q.gcReset) begin
								// restart loads the active bank or the reset code, clears pointer and speed mode; banks and write count survive
								d.gcReset = 1'b0; // RULE_17
								d.shadow = ld;
								d.chan = ld;
								d.ptr = 6'h00;
								d.hs = 1'b0;
								d.st = S_IDLE;
							end
						end
					end
				end
				S_TX: begin
					if (sclRise) begin
						d.cnt = q.cnt + 4'h1;
					end
					if (sclFall) begin
						if (q.cnt == 4'h8) begin
							d.sdaOe = 1'b0; // RULE_10
							d.st = S_RXACK;
						end else begin
							d.sh = {q.sh[6:0], 1'b0};
							d.sdaOe = !q.sh[6]; // RULE_11
						end
					end
				end
				S_RXACK: begin
					if (sclRise) begin
						if (!q.sda[1]) begin
							// reuse the ack exit to load and drive the next byte on the fall
							d.st = S_ACK;
							d.ackOn = 1'b1;
							d.ackWant = 1'b1;
							d.nxt = S_TX;
							d.role = (q.role == R_HI) ? R_LO : R_HI;
							if (q.role == R_LO) begin
								d.ptr = q.ptr + 6'h01;
							end
						end else begin
							d.st = S_IDLE;
						end
					end
				end
				default: begin
					d.st = S_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sampling at the core clock covers 400 kHz; high-speed rates need a faster core clock
	always_ff @(posedge clk or negedge resetn) begin // RULE_13
		if (!resetn) begin
			q <= '0;
			q.scl <= 3'h7;
			q.sda <= 3'h7;
			q.shadow <= {CH_N{CODE_RESET}};
			q.chan <= {CH_N{CODE_RESET}};
			q.left <= NV_WRITES_MAX;
		end else begin
			q <= d;
		end
	end
endmodule : grf_slave
`default_nettype wire

// *** grf_pkg.sv ***
// Functional notes
// RULE_01: sixteen gamma plus two common channels, 10-bit
// RULE_02: at most sixteen nonvolatile programming operations
// RULE_03: two nonvolatile banks, each a full curve
// RULE_04: device acts only as bus slave
// RULE_05: lines only pulled low, never driven high
// RULE_06: master makes clock, start and stop
// RULE_07: start is SDA falling while SCL high
// RULE_08: address sampled on SCL rise, last bit direction
// RULE_09: own address acknowledged low on ninth pulse
// RULE_10: eight data bits then receiver acknowledge
// RULE_11: SDA changes only while SCL low
// RULE_12: SDA change during SCL high is start/stop
// RULE_13: serial clock up to 400 kHz, 2.7 MHz
// RULE_14: stop is SDA rising while SCL high
// RULE_15: high-speed code 00001xxx is never acknowledged
// RULE_16: high-speed mode holds until next stop
// RULE_17: general call 00h then 06h resets device
// RULE_18: bytes shifted most significant bit first
package grf_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCL_FAST_KHZ  = 400;
	localparam int SCL_HS_KHZ    = 2700;
	localparam int SCL_PERIOD_NS = 1000000 / SCL_FAST_KHZ;
	// quarter of a fast-mode bit, a least time, so rounded up
	localparam int QTR_CYC       = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAMMA_N       = 16;
	localparam int CH_N          = GAMMA_N + 2;
	localparam int CODE_W        = 10;
	localparam int BANK_N        = 2;
	localparam int FIFO_DEPTH    = 32;
	localparam int WORD_W        = 1 + 6 + CODE_W;
	localparam logic [4:0] NV_WRITES_MAX = 5'h10;
	localparam logic [9:0] CODE_RESET    = 10'h200;
	// slave address value is arbitrary
	localparam logic [6:0] DEV_ADDR_DFLT = 7'h5a;
	localparam logic [7:0] GC_ADDR       = 8'h00;
	localparam logic [7:0] GC_RESET      = 8'h06;
	localparam logic [4:0] HS_CODE       = 5'h01;
	localparam logic [5:0] GAMMA_LAST    = 6'h0f;
	localparam logic [5:0] COM0_PTR      = 6'h12;
	localparam logic [5:0] COM1_PTR      = 6'h13;
	localparam logic [5:0] PTR_LAST_ACK  = 6'h17;
	typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} grf_op_e;
endpackage : grf_pkg

// *** grf_bus_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface grf_bus_if;
	logic sclOM;
	logic sclOeM;
	logic sdaOM;
	logic sdaOeM;
	logic sdaOS;
	logic sdaOeS;
	logic scl;
	logic sda;
	// wired-and with pull-up: a line is low only while someone enables a low drive
	assign scl = !(sclOeM && !sclOM);
	assign sda = !(sdaOeM && !sdaOM) && !(sdaOeS && !sdaOS);
	modport master (output sclOM, sclOeM, sdaOM, sdaOeM, input scl, sda);
	modport slave (output sdaOS, sdaOeS, input scl, sda);
endinterface : grf_bus_if
`default_nettype wire

// *** grf_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module grf_fifo import grf_pkg::*; #(
	parameter int W     = WORD_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// fill side
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	// drain side
	output logic              outValid,
	input  wire logic         outReady,
	output logic [W-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW:0]             wp;
		logic [AW:0]             rp;
	} grf_fifo_s;
	grf_fifo_s q, d;
	logic [AW:0] fill;

	assign fill     = q.wp - q.rp;
	assign inReady  = fill != (AW+1)'(DEPTH);
	assign outValid = fill != '0;
	assign outData  = q.mem[q.rp[AW-1:0]];

	always_comb begin
		d = q;
		if (inValid && inReady) begin
			d.mem[q.wp[AW-1:0]] = inData;
			d.wp = q.wp + (AW+1)'(1);
		end
		if (outValid && outReady) begin
			d.rp = q.rp + (AW+1)'(1);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : grf_fifo
`default_nettype wire

// *** grf_master.sv ***
`timescale 1ns/1ns
`default_nettype none
module grf_master import grf_pkg::*; #(
	parameter int QTR = QTR_CYC
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// serial bus
	grf_bus_if.master       bus,
	// command
	input  wire logic       cmdValid,
	output logic            cmdReady,
	input  wire grf_op_e    cmdOp,
	input  wire logic [7:0] cmdData,
	input  wire logic       cmdAck,
	// response
	output logic            rspValid,
	output logic [7:0]      rspData,
	output logic            rspAck
);
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} grf_mst_e;
	typedef struct packed {
		grf_mst_e   st;
		logic [7:0] div;
		logic [1:0] ph;
		logic [3:0] cnt;
		logic [8:0] tx;
		logic [8:0] rx;
		logic [1:0] sda;
		logic       sclOe;
		logic       sdaOe;
		logic       rdy;
		logic       rspV;
		logic [7:0] rspD;
		logic       rspA;
	} grf_master_s;
	grf_master_s q, d;

	assign bus.sclOM  = 1'b0; // RULE_05
	assign bus.sdaOM  = 1'b0;
	assign bus.sclOeM = q.sclOe; // RULE_06
	assign bus.sdaOeM = q.sdaOe;
	assign cmdReady   = q.rdy;
	assign rspValid   = q.rspV;
	assign rspData    = q.rspD;
	assign rspAck     = q.rspA;

	////////////////////////////////////////////////////////////////////////////
	// no clock stretching: the slave never holds SCL, so SCL is not read back
	always_comb begin
		logic tick;
		logic done;
		d = q;
		d.sda = {q.sda[0], bus.sda};
		d.rspV = 1'b0;
		tick = q.div == 8'(QTR - 1);
		done = 1'b0;
		d.div = tick ? 8'h00 : q.div + 8'h01;
		unique case (q.st)
			H_IDLE: begin
				if (cmdValid && q.rdy) begin
					d.rdy = 1'b0;
					d.ph = 2'h0;
					d.div = 8'h00;
					d.cnt = 4'h0;
					unique case (cmdOp)
						OP_START: d.st = H_START;
						OP_STOP:  d.st = H_STOP;
						OP_WRITE: begin
							d.tx = {cmdData, 1'b1}; // RULE_18 RULE_10
							d.st = H_BIT;
						end
						OP_READ: begin
							d.tx = {8'hff, !cmdAck}; // RULE_10
							d.st = H_BIT;
						end
					endcase
				end
			end
			H_START: begin
				if (tick) begin
					d.ph = q.ph + 2'h1;
					unique case (q.ph)
						2'h0: d.sdaOe = 1'b0;
						2'h1: d.sclOe = 1'b0;
						2'h2: d.sdaOe = 1'b1; // RULE_07
						2'h3: begin
							d.sclOe = 1'b1;
							done = 1'b1;
						end
					endcase
				end
			end
			H_STOP: begin
				if (tick) begin
					d.ph = q.ph + 2'h1;
					unique case (q.ph)
						2'h0: d.sdaOe = 1'b1;
						2'h1: d.sclOe = 1'b0;
						2'h2: d.sdaOe = 1'b0; // RULE_14
						2'h3: done = 1'b1;
					endcase
				end
			end
			H_BIT: begin
				if (tick) begin
					d.ph = q.ph + 2'h1;
					unique case (q.ph)
						2'h0: d.sdaOe = !q.tx[8]; // RULE_11
						2'h1: d.sclOe = 1'b0;
						2'h2: d.rx = {q.rx[7:0], q.sda[1]};
						2'h3: begin
							d.sclOe = 1'b1;
							d.tx = {q.tx[7:0], 1'b1};
							d.cnt = q.cnt + 4'h1;
							if (q.cnt == 4'h8) begin
								d.rspV = 1'b1;
								d.rspD = q.rx[8:1];
								d.rspA = !q.rx[0];
								done = 1'b1;
							end
						end
					endcase
				end
			end
		endcase
		if (done) begin
			d.st = H_IDLE;
			d.rdy = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
			q.sda <= 2'h3;
			q.rdy <= 1'b1;
		end else begin
			q <= d;
		end
	end
endmodule : grf_master
`default_nettype wire

// *** grf_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module grf_properties import grf_pkg::*; #(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// master drives
	input wire logic sclOM,
	input wire logic sclOeM,
	input wire logic sdaOM,
	input wire logic sdaOeM,
	// slave drives
	input wire logic sdaOS,
	input wire logic sdaOeS,
	// resolved lines
	input wire logic scl,
	input wire logic sda
);
	logic       sclQ;
	logic       sdaQ;
	logic [3:0] bitCnt;
	logic [1:0] byteIdx;
	logic [7:0] shReg;
	logic [7:0] addrByte;
	logic       sclRise;
	logic       startSeen;
	logic       stopSeen;
	logic       ninth;
	assign sclRise   = scl && !sclQ;
	assign startSeen = scl && sclQ && sdaQ && !sda;
	assign stopSeen  = scl && sclQ && !sdaQ && sda;
	assign ninth     = sclRise && bitCnt == 4'h8;
	////////////////////////////////////////////////////////////
	// framing rebuilt from the wire alone, so a slip in either end shows
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclQ     <= 1'b1;
			sdaQ     <= 1'b1;
			bitCnt   <= 4'h0;
			byteIdx  <= 2'h0;
			shReg    <= 8'h00;
			addrByte <= 8'h00;
		end else begin
			sclQ <= scl;
			sdaQ <= sda;
			if (startSeen || stopSeen) begin
				bitCnt  <= 4'h0;
				byteIdx <= 2'h0;
			end else if (ninth) begin
				bitCnt <= 4'h0;
				if (byteIdx == 2'h0) addrByte <= shReg;
				if (byteIdx != 2'h3) byteIdx <= byteIdx + 2'h1;
			end else if (sclRise) begin
				bitCnt <= bitCnt + 4'h1;
				shReg  <= {shReg[6:0], sda};
			end
		end
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	slave_low_only_a: assert property (sdaOeS |-> !sdaOS)
		else $error("slave drives sda high");
	master_low_only_a: assert property ((sdaOeM |-> !sdaOM) and (sclOeM |-> !sclOM))
		else $error("master drives a line high");
	slave_edge_low_a: assert property ($changed(sdaOeS) |-> !scl)
		else $error("slave moved sda while scl high");
	ack_hold_a: assert property (sclRise && sdaOeS |-> sdaOeS[*6])
		else $error("slave let go of sda inside a high phase");
	start_owner_a: assert property (startSeen |-> sdaOeM && !sdaOeS)
		else $error("start not made by master");
	stop_owner_a: assert property (stopSeen |-> $past(sdaOeM) && !sdaOeS)
		else $error("stop not made by master");
	addr_listen_a: assert property (sclRise && byteIdx == 2'h0 && bitCnt < 4'h8 |-> !sdaOeS)
		else $error("slave drove inside address byte");
	addr_match_a: assert property (ninth && byteIdx == 2'h0 |->
		sdaOeS == (shReg[7:1] == DEV_ADDR || shReg == GC_ADDR))
		else $error("address acknowledge wrong");
	hs_nack_a: assert property (ninth && byteIdx == 2'h0 && shReg[7:3] == HS_CODE |-> !sdaOeS)
		else $error("high-speed code acknowledged");
	gc_data_a: assert property (ninth && byteIdx == 2'h1 && addrByte == GC_ADDR |->
		sdaOeS == (shReg == GC_RESET))
		else $error("general call data acknowledge wrong");
	cover property (ninth && byteIdx == 2'h0 && sdaOeS);
	cover property (ninth && byteIdx == 2'h1 && addrByte == GC_ADDR && sdaOeS);
	cover property (stopSeen);
endmodule : grf_properties
`default_nettype wire

// *** tb_gamma_ref_i2c_slave_front.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_gamma_ref_i2c_slave_front import grf_pkg::*; ;
	typedef struct packed {logic [7:0] data; logic ack; logic [7:0] mask;} grf_exp_s;
	logic                   clk;
	logic                   resetn;
	logic                   cmdValid;
	logic                   cmdReady;
	grf_op_e                cmdOp;
	logic [7:0]             cmdData;
	logic                   cmdAck;
	logic                   rspValid;
	logic [7:0]             rspData;
	logic                   rspAck;
	logic                   bankSel;
	logic                   progReq;
	logic                   progBank;
	logic                   drainHold;
	logic [CH_N*CODE_W-1:0] chanCode;
	logic                   hsMode;
	logic [4:0]             nvWritesLeft;
	logic                   bankActive;
	logic [9:0]             expCh [CH_N];
	grf_exp_s               expQ [$];
	grf_exp_s               e;
	int                     err_total;
	int                     checks_done;
	grf_bus_if bus();
	grf_master #(.QTR(4)) grf_master_inst (.clk(clk), .resetn(resetn), .bus(bus.master),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdData(cmdData), .cmdAck(cmdAck),
		.rspValid(rspValid), .rspData(rspData), .rspAck(rspAck));
	grf_slave grf_slave_inst (.clk(clk), .resetn(resetn), .bus(bus.slave), .bankSel(bankSel),
		.progReq(progReq), .progBank(progBank), .drainHold(drainHold), .chanCode(chanCode),
		.hsMode(hsMode), .nvWritesLeft(nvWritesLeft), .bankActive(bankActive));
	grf_properties #(.DEV_ADDR(DEV_ADDR_DFLT)) grf_properties_inst (.clk(clk), .resetn(resetn),
		.sclOM(bus.sclOM), .sclOeM(bus.sclOeM), .sdaOM(bus.sdaOM), .sdaOeM(bus.sdaOeM),
		.sdaOS(bus.sdaOS), .sdaOeS(bus.sdaOeS), .scl(bus.scl), .sda(bus.sda));
	initial clk = 1'b0;
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////
	task automatic mism(input string msg);
		err_total++;
		$display("[ERR] %0t %s", $time, msg);
	endtask : mism
	task automatic cmp(input logic [9:0] got, input logic [9:0] exp, input string what);
		checks_done++;
		if (got !== exp) mism($sformatf("%s got %h exp %h", what, got, exp));
	endtask : cmp
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	// one command; the expected answer is noted at the accepting edge
	task automatic xfer(input grf_op_e op, input logic [7:0] d, input logic a, input logic ea, input logic [7:0] m);
		int n;
		cmdValid <= 1'b1;
		cmdOp    <= op;
		cmdData  <= d;
		cmdAck   <= a;
		@(posedge clk);
		while (cmdReady !== 1'b1) @(posedge clk);
		cmdValid <= 1'b0;
		if (op == OP_WRITE || op == OP_READ) expQ.push_back('{d, ea, m});
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cmdReady !== 1'b1 && n < 1000);
		if (n >= 1000) mism("command hang");
	endtask : xfer
	task automatic tx_open(input logic [7:0] a, input logic ea);
		xfer(OP_START, 8'h00, 1'b0, 1'b0, 8'h00);
		xfer(OP_WRITE, a, 1'b0, ea, 8'hff);
	endtask : tx_open
	task automatic tx_close;
		xfer(OP_STOP, 8'h00, 1'b0, 1'b0, 8'h00);
		repeat (4) @(posedge clk);
		cmp(10'({bus.scl, bus.sda}), 10'h003, "idle lines");
	endtask : tx_close
	task automatic wr_word(input logic [9:0] v, input logic upd, input logic ackLo);
		xfer(OP_WRITE, {upd, 5'h00, v[9:8]}, 1'b0, 1'b1, 8'hff);
		xfer(OP_WRITE, v[7:0], 1'b0, ackLo, 8'hff);
	endtask : wr_word
	task automatic cmp_curve(input logic blank);
		for (int i = 0; i < CH_N; i++) cmp(chanCode[i*CODE_W +: CODE_W], blank ? CODE_RESET : expCh[i], "channel");
	endtask : cmp_curve
	////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (rspValid === 1'b1) begin
			if (expQ.size() == 0) mism("response with nothing expected");
			else begin
				e = expQ.pop_front();
				checks_done++;
				if (rspAck !== e.ack || ((rspData ^ e.data) & e.mask) !== 8'h00) mism("response mismatch");
			end
		end
	end
	initial begin
		repeat (60000) @(posedge clk);
		mism("watchdog expired");
		close_out();
	end
	initial begin
		logic [9:0] v;
		resetn = 1'b0;
		cmdValid = 1'b0;
		cmdOp = OP_START;
		cmdData = 8'h00;
		cmdAck = 1'b0;
		{bankSel, progReq, progBank, drainHold} = 4'h0;
		err_total = 0;
		checks_done = 0;
		void'($urandom(91848));
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		cmp_curve(1'b1);
		cmp(10'(nvWritesLeft), 10'(NV_WRITES_MAX), "writes left");
		// burst across pointers 00h to 13h incl. the dropped 10h and 11h, update on the last word only
		tx_open({DEV_ADDR_DFLT, 1'b0}, 1'b1);
		xfer(OP_WRITE, 8'h00, 1'b0, 1'b1, 8'hff);
		for (int p = 0; p < 20; p++) begin
			v = 10'($urandom);
			if (p < 16) expCh[p] = v;
			else if (p > 17) expCh[p-2] = v;
			wr_word(v, p == 19, 1'b1);
		end
		tx_close();
		cmp_curve(1'b0);
		tx_open({DEV_ADDR_DFLT, 1'b0}, 1'b1);
		xfer(OP_WRITE, 8'h00, 1'b0, 1'b1, 8'hff);
		tx_open({DEV_ADDR_DFLT, 1'b1}, 1'b1);
		for (int i = 0; i < 4; i++) xfer(OP_READ, i[0] ? expCh[i/2][7:0] : {6'h00, expCh[i/2][9:8]},
			i < 3, i < 3, i[0] ? 8'hff : 8'h03);
		tx_close();
		tx_open({DEV_ADDR_DFLT ^ 7'h01, 1'b0}, 1'b0);
		tx_close();
		// pointer beyond the acknowledged range is refused
		tx_open({DEV_ADDR_DFLT, 1'b0}, 1'b1);
		xfer(OP_WRITE, 8'h18, 1'b0, 1'b0, 8'hff);
		tx_close();
		tx_open(8'h0d, 1'b0);
		cmp(10'(hsMode), 10'h001, "hs set");
		tx_open({DEV_ADDR_DFLT, 1'b0}, 1'b1);
		cmp(10'(hsMode), 10'h001, "hs kept");
		tx_close();
		cmp(10'(hsMode), 10'h000, "hs cleared");
		tx_open({GC_ADDR[7:1], 1'b0}, 1'b1);
		xfer(OP_WRITE, GC_RESET + 8'h01, 1'b0, 1'b0, 8'hff);
		tx_close();
		cmp_curve(1'b0);
		progBank <= 1'b1;
		progReq <= 1'b1;
		@(posedge clk);
		progReq <= 1'b0;
		repeat (3) @(posedge clk);
		cmp(10'(nvWritesLeft), 10'h00f, "writes left");
		tx_open({GC_ADDR[7:1], 1'b0}, 1'b1);
		xfer(OP_WRITE, GC_RESET, 1'b0, 1'b1, 8'hff);
		tx_close();
		cmp_curve(1'b1);
		bankSel <= 1'b1;
		repeat (10) @(posedge clk);
		cmp_curve(1'b0);
		cmp(10'(bankActive), 10'h001, "bank");
		bankSel <= 1'b0;
		repeat (10) @(posedge clk);
		cmp_curve(1'b1);
		// one pulse more than the store allows; the count must stop at zero
		repeat (16) begin
			progReq <= 1'b1;
			@(posedge clk);
			progReq <= 1'b0;
			@(posedge clk);
		end
		repeat (3) @(posedge clk);
		cmp(10'(nvWritesLeft), 10'h000, "writes left");
		// stalled drain: 32 words fill the buffer, the 33rd low byte is refused
		drainHold <= 1'b1;
		expCh[16] = CODE_RESET;
		expCh[17] = CODE_RESET;
		for (int t = 0; t < 3; t++) begin
			tx_open({DEV_ADDR_DFLT, 1'b0}, 1'b1);
			xfer(OP_WRITE, 8'h00, 1'b0, 1'b1, 8'hff);
			for (int w = 0; w < 16 && (t < 2 || w == 0); w++) begin
				v = 10'($urandom);
				if (t < 2) expCh[w] = v;
				wr_word(v, t == 1 && w == 15, t < 2);
			end
			tx_close();
		end
		cmp_curve(1'b1);
		drainHold <= 1'b0;
		repeat (80) @(posedge clk);
		cmp_curve(1'b0);
		close_out();
	end
endmodule : tb_gamma_ref_i2c_slave_front
`default_nettype wire
